//--- hw/touch_regs_map.svh
// register offsets, field positions, reset values and timing counts of the touch control bank
`ifndef TOUCH_REGS_MAP_SVH
`define TOUCH_REGS_MAP_SVH
`define ADDR_GEN_CONTROL_TWO 8'h09
`define ADDR_RELOAD_LO 8'h0A
`define ADDR_RELOAD_HI 8'h0B
`define ADDR_HOLD_LO 8'h0C
`define ADDR_HOLD_HI 8'h0D
`define ADDR_CAL_LO 8'h0E
`define ADDR_CAL_HI 8'h0F
`define ADDR_LEVEL_1_4 8'h10
`define ADDR_LEVEL_5_8 8'h11
`define ADDR_LEVEL_9_12 8'h12
`define ADDR_LEVEL_13_16 8'h13
`define ADDR_GUARD 8'h3B
`define BIT_MULTI 5
`define BIT_IMP 4
`define BIT_SOFT_RST 3
`define BIT_SLEEP 2
`define RST_GEN_CONTROL_TWO 8'h01
`define RST_RELOAD 16'hFFFE
`define RST_HOLD 16'hFFFE
`define RST_CAL 16'h0000
`define RST_GUARD 8'h00
`define GUARD_KEY 8'hA5
`define INIT_DONE 2'h3
`define SLEEP_DIV_DEFAULT 8
`endif

//--- hw/touch_regs_pkg.sv
// types carried by the touch control register bank
package touch_regs_pkg;
  typedef struct packed {
    logic [1:0] zero;
    logic multi_out;
    logic low_imp;
    logic soft_reset_bit;
    logic sleep;
    logic [1:0] init;
  } gen_control_t;
  typedef struct packed {
    logic [15:0] reload;
    logic [15:0] sense_hold;
    logic [15:0] cal_hold;
  } chan_ctrl_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic multi_out;
    logic low_imp;
    logic sleep;
    logic digital_reset;
    logic init_done;
    logic [15:0] reload;
    logic [15:0] sense_en;
    logic [15:0] cal_en;
  } fe_ctrl_t;
  typedef logic [31:0] level_bank_t;
endpackage : touch_regs_pkg

//--- hw/touch_sensor_control_regs.sv
// control and status register bank of the 16-channel touch sensor
`timescale 1ns/1ps
`default_nettype none
`include "touch_regs_map.svh"

module touch_sensor_control_regs
  import touch_regs_pkg::*;
#(
  parameter int SLEEP_DIV = `SLEEP_DIV_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register access from the serial interface engine
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // touch levels from the sensing core, same clock
  input wire level_bank_t level_in,
  // controls to the sensing core and analog front end
  output fe_ctrl_t fe_ctrl
);

  // a divider of one would make sleep identical to normal operation
  if (SLEEP_DIV < 2) begin : g_check
    $error("SLEEP_DIV must be at least 2");
  end

  localparam int CW = $clog2(SLEEP_DIV);
  localparam logic [CW-1:0] DIV_LAST = CW'(SLEEP_DIV - 1);

  gen_control_t gen_reg, gen_next;
  chan_ctrl_t chan_reg, chan_next;
  logic [7:0] guard_reg, guard_next;
  level_bank_t level_reg, level_next;
  logic [CW-1:0] div_reg, div_next;
  logic [7:0] rdata_next;
  logic rvalid_next;
  fe_ctrl_t fe_next;
  logic guard_open;
  logic sleep_tick;
  logic sample_en;

  // register writes; the mode bit is shielded by the guard byte against noisy writes
  always_comb begin
    gen_next = gen_reg;
    chan_next = chan_reg;
    guard_next = guard_reg;
    guard_open = (guard_reg == `GUARD_KEY);
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `ADDR_GEN_CONTROL_TWO: begin
          if (guard_open) begin
            gen_next.multi_out = reg_req.wdata[`BIT_MULTI];
          end
          gen_next.low_imp = reg_req.wdata[`BIT_IMP];
          gen_next.soft_reset_bit = reg_req.wdata[`BIT_SOFT_RST];
          gen_next.sleep = reg_req.wdata[`BIT_SLEEP];
          gen_next.init = reg_req.wdata[1:0];
        end
        `ADDR_RELOAD_LO: chan_next.reload[7:0] = reg_req.wdata;
        `ADDR_RELOAD_HI: chan_next.reload[15:8] = reg_req.wdata;
        `ADDR_HOLD_LO: chan_next.sense_hold[7:0] = reg_req.wdata;
        `ADDR_HOLD_HI: chan_next.sense_hold[15:8] = reg_req.wdata;
        `ADDR_CAL_LO: chan_next.cal_hold[7:0] = reg_req.wdata;
        `ADDR_CAL_HI: chan_next.cal_hold[15:8] = reg_req.wdata;
        `ADDR_GUARD: guard_next = reg_req.wdata;
        default: ; // read-only and unmapped writes are dropped
      endcase
    end
  end

  // sleep slows result refresh to one sample per divider period
  always_comb begin
    div_next = '0;
    sleep_tick = 1'b0;
    if (gen_reg.sleep && !gen_reg.soft_reset_bit) begin
      sleep_tick = (div_reg == DIV_LAST);
      div_next = sleep_tick ? '0 : div_reg + CW'(1);
    end
    sample_en = !gen_reg.sleep || sleep_tick;
  end

  // touch levels: cleared by soft reset, zero for held channels
  always_comb begin
    level_next = level_reg;
    for (int ch = 0; ch < 16; ch++) begin
      if (gen_reg.soft_reset_bit || chan_reg.sense_hold[ch]) begin
        level_next[2*ch +: 2] = 2'h0;
      end else if (sample_en) begin
        level_next[2*ch +: 2] = level_in[2*ch +: 2];
      end
    end
  end

  // read mux; unmapped offsets read zero, reserved bits 7:6 of control two read zero
  always_comb begin
    rdata_next = 8'h00;
    rvalid_next = reg_req.rd;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `ADDR_GEN_CONTROL_TWO: rdata_next = gen_reg;
        `ADDR_RELOAD_LO: rdata_next = chan_reg.reload[7:0];
        `ADDR_RELOAD_HI: rdata_next = chan_reg.reload[15:8];
        `ADDR_HOLD_LO: rdata_next = chan_reg.sense_hold[7:0];
        `ADDR_HOLD_HI: rdata_next = chan_reg.sense_hold[15:8];
        `ADDR_CAL_LO: rdata_next = chan_reg.cal_hold[7:0];
        `ADDR_CAL_HI: rdata_next = chan_reg.cal_hold[15:8];
        `ADDR_LEVEL_1_4: rdata_next = level_reg[7:0];
        `ADDR_LEVEL_5_8: rdata_next = level_reg[15:8];
        `ADDR_LEVEL_9_12: rdata_next = level_reg[23:16];
        `ADDR_LEVEL_13_16: rdata_next = level_reg[31:24];
        `ADDR_GUARD: rdata_next = guard_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // front-end controls follow the next register values so they move with the write
  always_comb begin
    fe_next.multi_out = gen_next.multi_out;
    fe_next.low_imp = gen_next.low_imp;
    fe_next.sleep = gen_next.sleep;
    fe_next.digital_reset = gen_next.soft_reset_bit;
    fe_next.init_done = (gen_next.init == `INIT_DONE);
    fe_next.reload = gen_next.soft_reset_bit ? 16'h0000 : chan_next.reload;
    fe_next.sense_en = gen_next.soft_reset_bit ? 16'h0000 : ~chan_next.sense_hold;
    fe_next.cal_en = gen_next.soft_reset_bit ? 16'h0000
                   : ~(chan_next.sense_hold | chan_next.cal_hold);
  end

  // state registers; the serial side registers are untouched by soft reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gen_reg <= `RST_GEN_CONTROL_TWO;
      chan_reg <= {`RST_RELOAD, `RST_HOLD, `RST_CAL};
      guard_reg <= `RST_GUARD;
      level_reg <= '0;
      div_reg <= '0;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      fe_ctrl <= '0;
    end else begin
      gen_reg <= gen_next;
      chan_reg <= chan_next;
      guard_reg <= guard_next;
      level_reg <= level_next;
      div_reg <= div_next;
      reg_rdata <= rdata_next;
      reg_rvalid <= rvalid_next;
      fe_ctrl <= fe_next;
    end
  end

  // checks sample on the register clock and stay quiet while reset is held
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  multi_guarded_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_GEN_CONTROL_TWO && guard_reg != `GUARD_KEY
    |=> $stable(fe_ctrl.multi_out))
    else $error("mode bit changed without guard key");
  multi_write_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_GEN_CONTROL_TWO && guard_reg == `GUARD_KEY
    |=> fe_ctrl.multi_out == $past(reg_req.wdata[`BIT_MULTI]))
    else $error("mode bit did not take written value");
  imp_write_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_GEN_CONTROL_TWO
    |=> fe_ctrl.low_imp == $past(reg_req.wdata[`BIT_IMP]))
    else $error("impedance select did not follow write");
  soft_clear_a: assert property (
    fe_ctrl.digital_reset ##1 fe_ctrl.digital_reset
    |-> level_reg == 32'h0000_0000 && fe_ctrl.sense_en == 16'h0000)
    else $error("soft reset did not clear sensing state");
  soft_sticky_a: assert property (
    fe_ctrl.digital_reset && !(reg_req.wr && reg_req.addr == `ADDR_GEN_CONTROL_TWO)
    |=> fe_ctrl.digital_reset)
    else $error("soft reset bit cleared itself");
  sleep_rate_a: assert property (
    gen_reg.sleep && !sleep_tick && !gen_reg.soft_reset_bit && chan_reg.sense_hold == 16'h0000
    |=> $stable(level_reg))
    else $error("levels refreshed between sleep ticks");
  reload_out_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_RELOAD_LO && !gen_reg.soft_reset_bit
    |=> fe_ctrl.reload[7:0] == $past(reg_req.wdata))
    else $error("reload mask did not follow write");
  hold_gate_a: assert property (
    (fe_ctrl.cal_en & chan_reg.sense_hold) == 16'h0000)
    else $error("held channel still calibrating");
  // fe_ctrl holds zeros through reset, so the gating check waits one cycle after release
  cal_gate_a: assert property (
    $past(rst_n) && !fe_ctrl.digital_reset
    |-> (fe_ctrl.cal_en & chan_reg.cal_hold) == 16'h0000
        && fe_ctrl.sense_en == ~chan_reg.sense_hold)
    else $error("calibration hold gating wrong");
  held_level_a: assert property (
    chan_reg.sense_hold[0] ##1 chan_reg.sense_hold[0] |-> level_reg[1:0] == 2'h0)
    else $error("held channel shows a level");
  level_read_a: assert property (
    reg_req.rd && reg_req.addr == `ADDR_LEVEL_13_16
    |=> reg_rvalid && reg_rdata == $past(level_reg[31:24]))
    else $error("level byte read wrong");
  guard_read_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_GUARD ##1 reg_req.rd && reg_req.addr == `ADDR_GUARD
    |=> reg_rdata == $past(reg_req.wdata, 2))
    else $error("guard byte read back wrong");

  // reads answer exactly one cycle after the strobe and idle at zero otherwise
  read_answer_a: assert property (
    reg_req.rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  read_idle_a: assert property (
    !reg_req.rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read answer without a strobe");
  // reserved top bits of control two never show a one
  ctrl_reserved_a: assert property (
    reg_req.rd && reg_req.addr == `ADDR_GEN_CONTROL_TWO |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved control bits read nonzero");
  // level bytes are read-only, so a write there must leave the control, channel mask and guard registers alone
  level_ro_a: assert property (
    reg_req.wr && reg_req.addr >= `ADDR_LEVEL_1_4 && reg_req.addr <= `ADDR_LEVEL_13_16
    |=> $stable(gen_reg) && $stable(chan_reg) && $stable(guard_reg))
    else $error("write to a level byte changed a register");
  // the guard byte only moves on its own write
  guard_hold_a: assert property (
    !(reg_req.wr && reg_req.addr == `ADDR_GUARD) |=> $stable(guard_reg))
    else $error("guard byte changed without a write");
  // awake and unheld, channel 1 tracks the core one cycle behind
  awake_track_a: assert property (
    !gen_reg.sleep && !gen_reg.soft_reset_bit && !chan_reg.sense_hold[0]
    |=> level_reg[1:0] == $past(level_in[1:0]))
    else $error("awake level did not follow the core");
  sleep_follow_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_GEN_CONTROL_TWO
    |=> fe_ctrl.sleep == $past(reg_req.wdata[`BIT_SLEEP]))
    else $error("sleep control did not follow write");
  // the divider never passes its last count, or sleep sampling would stall
  div_range_a: assert property (
    div_reg <= DIV_LAST)
    else $error("sleep divider out of range");
  // init bits: the front end sees them complete only on the 11 pattern
  init_follow_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_GEN_CONTROL_TWO
    |=> fe_ctrl.init_done == ($past(reg_req.wdata[1:0]) == `INIT_DONE))
    else $error("init complete flag wrong");
  // setting soft reset stops reload and calibration at once
  soft_set_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_GEN_CONTROL_TWO && reg_req.wdata[`BIT_SOFT_RST]
    |=> fe_ctrl.digital_reset && fe_ctrl.reload == 16'h0000 && fe_ctrl.cal_en == 16'h0000)
    else $error("soft reset left the core running");
  // a calibration hold write reaches the front end with sensing hold still applied
  cal_write_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_CAL_LO && !gen_reg.soft_reset_bit
    |=> fe_ctrl.cal_en[7:0] == ~($past(chan_reg.sense_hold[7:0]) | $past(reg_req.wdata)))
    else $error("calibration hold did not follow write");
  // sensing hold writes turn the matching enables off on the next edge
  hold_lo_write_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_HOLD_LO && !gen_reg.soft_reset_bit
    |=> fe_ctrl.sense_en[7:0] == ~$past(reg_req.wdata))
    else $error("low sensing hold did not follow write");
  hold_hi_write_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_HOLD_HI && !gen_reg.soft_reset_bit
    |=> fe_ctrl.sense_en[15:8] == ~$past(reg_req.wdata))
    else $error("high sensing hold did not follow write");
  reload_hi_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_RELOAD_HI && !gen_reg.soft_reset_bit
    |=> fe_ctrl.reload[15:8] == $past(reg_req.wdata))
    else $error("high reload mask did not follow write");
  cal_hi_write_a: assert property (
    reg_req.wr && reg_req.addr == `ADDR_CAL_HI && !gen_reg.soft_reset_bit
    |=> fe_ctrl.cal_en[15:8] == ~($past(chan_reg.sense_hold[15:8]) | $past(reg_req.wdata)))
    else $error("high calibration hold did not follow write");
  // first level byte carries channels 1 to 4
  level_low_read_a: assert property (
    reg_req.rd && reg_req.addr == `ADDR_LEVEL_1_4
    |=> reg_rvalid && reg_rdata == $past(level_reg[7:0]))
    else $error("first level byte read wrong");

  multi_change_c: cover property ($changed(fe_ctrl.multi_out));
  sleep_sample_c: cover property (gen_reg.sleep && sleep_tick);
  soft_reset_c: cover property ($rose(fe_ctrl.digital_reset) ##[1:20] $fell(fe_ctrl.digital_reset));

  // the refused mode write and a held channel with a live level
  guard_refuse_c: cover property (
    reg_req.wr && reg_req.addr == `ADDR_GEN_CONTROL_TWO && !guard_open);
  held_live_c: cover property (chan_reg.sense_hold[0] && level_in[1:0] != 2'h0);

endmodule : touch_sensor_control_regs
`default_nettype wire

//--- tb/host_model.sv
// host side model: register requests as the serial engine would hand them over
`timescale 1ns/1ps
`default_nettype none
module host_model
  import touch_regs_pkg::*;
(
  // clock
  input wire logic clock,
  // register port
  output reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial reg_req = '0;
  // one-cycle write strobe, settled a moment after the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    reg_req.wr <= 1'b0;
    #1;
  endtask : wr_reg
  // rdata is only trusted in the single cycle that rvalid stands
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    reg_req.rd <= 1'b0;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : rd_reg
  // initialisation order: guard key first, then mode and init bits
  task automatic init_seq();
    wr_reg(8'h3B, 8'hA5);
    wr_reg(8'h09, 8'h33);
  endtask : init_seq
endmodule : host_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench of the touch control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb
  import touch_regs_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  level_bank_t level_in = '0;
  reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  fe_ctrl_t fe;
  logic [7:0] d;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  localparam logic [7:0] RA [12] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
    8'h10, 8'h11, 8'h12, 8'h13, 8'h3B};
  localparam logic [7:0] RV [12] = '{8'h01, 8'hFE, 8'hFF, 8'hFE, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [31:0] LVL = 32'hE4E4_1B1B;
  always #10 clock = ~clock;
  touch_sensor_control_regs #(.SLEEP_DIV(2)) touch_sensor_control_regs_inst (
    .clock(clock), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .level_in(level_in), .fe_ctrl(fe));
  host_model host_model_inst (
    .clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // hang guard, far above the hundred or so cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host_model_inst.rd_reg(a, d);
    `CHK("rdata", e, d)
  endtask : rd_chk
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    // reset values of the whole map, then an unmapped offset
    for (int i = 0; i < 12; i++) begin
      rd_chk(RA[i], RV[i]);
    end
    rd_chk(8'h20, 8'h00);
    `CHK("init_done", 1'b0, fe.init_done)
    // mode bit refused without the key, init bits accepted
    host_model_inst.wr_reg(8'h09, 8'h23);
    rd_chk(8'h09, 8'h03);
    `CHK("init_done", 1'b1, fe.init_done)
    host_model_inst.init_seq();
    rd_chk(8'h3B, 8'hA5);
    rd_chk(8'h09, 8'h33);
    `CHK("multi_out", 1'b1, fe.multi_out)
    `CHK("low_imp", 1'b1, fe.low_imp)
    host_model_inst.wr_reg(8'h3B, 8'h00);
    host_model_inst.wr_reg(8'h09, 8'h13);
    rd_chk(8'h09, 8'h33);
    // channel masks
    host_model_inst.wr_reg(8'h0A, 8'h5A);
    `CHK("reload", 16'hFF5A, fe.reload)
    host_model_inst.wr_reg(8'h0C, 8'h00);
    host_model_inst.wr_reg(8'h0D, 8'h00);
    host_model_inst.wr_reg(8'h0E, 8'h0F);
    `CHK("sense_en", 16'hFFFF, fe.sense_en)
    `CHK("cal_en", 16'hFFF0, fe.cal_en)
    // level packing, read-only bytes, held channel forced to none
    level_in <= LVL;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'h10 + 8'(i), LVL[8*i +: 8]);
    end
    host_model_inst.wr_reg(8'h10, 8'hFF);
    rd_chk(8'h10, 8'h1B);
    host_model_inst.wr_reg(8'h0C, 8'h01);
    rd_chk(8'h10, 8'h18);
    // sleep enter and leave
    host_model_inst.wr_reg(8'h09, 8'h37);
    `CHK("sleep", 1'b1, fe.sleep)
    host_model_inst.wr_reg(8'h09, 8'h33);
    `CHK("sleep", 1'b0, fe.sleep)
    // soft reset stays until cleared, registers kept, levels cleared
    host_model_inst.wr_reg(8'h09, 8'h3B);
    repeat (4) @(posedge clock);
    #1;
    `CHK("digital_reset", 1'b1, fe.digital_reset)
    `CHK("sense_en", 16'h0000, fe.sense_en)
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h09, 8'h3B);
    host_model_inst.wr_reg(8'h09, 8'h33);
    `CHK("digital_reset", 1'b0, fe.digital_reset)
    repeat (3) @(posedge clock);
    rd_chk(8'h11, 8'h1B);
    `CHK("sense_en", 16'hFFFE, fe.sense_en)
    finish_test();
  end
endmodule : tb
`default_nettype wire
